// ### pfsm_params.svh
`ifndef PFSM_PARAMS_SVH
`define PFSM_PARAMS_SVH

// Field level reported while a protective field is free.
`define PFSM_FIELD_FREE 1'h1
// Field level reported while a protective field is interrupted.
`define PFSM_FIELD_BLOCKED 1'h0
// Level of an output that demands robot downtime.
`define PFSM_OUT_SAFE 1'h0
// Level of an output that permits robot motion.
`define PFSM_OUT_RUN 1'h1
// Level of a pushbutton input while it is actuated.
`define PFSM_BUTTON_ON 1'h1
// Reset value of every synchroniser stage for a field input.
`define PFSM_SYNC_FIELD_INIT 3'h0
// Unused; every button synchroniser stage resets to PFSM_BUTTON_ON, not to this value.
`define PFSM_SYNC_BUTTON_INIT 3'h0
// Reset level of a status flag that starts clear.
`define PFSM_FLAG_CLEAR 1'h0
// Reset level of a status flag that starts set.
`define PFSM_FLAG_SET 1'h1

`endif

// ### pfsm_pkg.sv
package pfsm_pkg;

  // Sequence monitor states.
  typedef enum logic [2:0] {
    PFSM_INIT,
    PFSM_NO_FIELD,
    PFSM_OUTER_IN,
    PFSM_BOTH_IN,
    PFSM_OUTER_OUT,
    PFSM_ERROR,
    PFSM_WAIT_RESTART
  } pfsm_state_t;

endpackage

// ### pfsm_sync.sv
`timescale 1ns/1ps
`include "pfsm_params.svh"

module pfsm_sync
  import pfsm_pkg::*;
#(
  parameter logic INIT = 1'h0
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Raw input and filtered level.
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } pfsm_sync_st_t;

  pfsm_sync_st_t s_q;
  pfsm_sync_st_t s_d;

  // The first stage feeds only the second; the level moves once stages two and three agree.
  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[1:0], din};
    if (s_q.stage[1] == s_q.stage[2]) begin
      s_d.level = s_q.stage[2];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{stage: {3{INIT}}, level: INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.level;

endmodule

// ### pfsm_buttons.sv
`timescale 1ns/1ps
`include "pfsm_params.svh"

module pfsm_buttons
  import pfsm_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Filtered pushbutton levels.
  input  wire logic reset_btn,
  input  wire logic restart_btn,
  // One-cycle pulses on the press edge.
  output logic      reset_press,
  output logic      restart_press
);

  typedef struct packed {
    logic rst_prev;
    logic rs_prev;
  } pfsm_btn_st_t;

  pfsm_btn_st_t s_q;
  pfsm_btn_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rst_prev = reset_btn;
    s_d.rs_prev  = restart_btn;
  end

  // Previous levels start as pressed so that a button held through reset gives no edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{rst_prev: `PFSM_BUTTON_ON, rs_prev: `PFSM_BUTTON_ON};
    end else begin
      s_q <= s_d;
    end
  end

  assign reset_press   = (reset_btn == `PFSM_BUTTON_ON) && (s_q.rst_prev != `PFSM_BUTTON_ON);
  assign restart_press = (restart_btn == `PFSM_BUTTON_ON) && (s_q.rs_prev != `PFSM_BUTTON_ON);

endmodule

// ### pfsm_monitor.sv
`timescale 1ns/1ps
`include "pfsm_params.svh"

// Summary of operation
// R1: Safety outputs drop to 0 whenever the safe state holds; 0 means robot downtime.
// R2: An interrupted inner field enters the safe state.
// R3: A field order outside the permitted restart sequence enters the safe state.
// R4: An actuated emergency stop enters the safe state.
// R5: Any controller, module or scanner fault forces the outputs to 0.
// R6: A lost controller-to-scanner link forces the outputs to 0.
// R7: An interrupted outer field requests reduced robot speed.
// R8: An interrupted inner field demands a protective stop.
// R9: Restart is permitted only while every field is free.
// R10: The order of field interruption and freeing is tracked for restart.
// R11: A complete approach and departure in order restarts automatically.
// R12: After a sequence error only an operator action restarts the robot.
// R13: The scanner reports a free field as 1 and an interrupted one as 0.
// R14: Outer and inner fields freed in the same cycle is a sequence error.
// R15: Inner field interrupted before the outer field is a sequence error.
// R16: After an error the operator presses reset, then restart, before restart occurs.
// R17: The safe state stays latched until every restart condition is met.

module pfsm_monitor
  import pfsm_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Scanner field states, 1 while free.
  input  wire logic outer_field,
  input  wire logic inner_field,
  // Pushbuttons, 1 while actuated.
  input  wire logic estop_btn,
  input  wire logic reset_btn,
  input  wire logic restart_btn,
  // Fault reports, 1 while present.
  input  wire logic ctrl_fault,
  input  wire logic module_fault,
  input  wire logic scanner_fault,
  input  wire logic link_lost,
  // Networked safety outputs toward the robot, 0 demands downtime, except on full_speed where 0 requests reduced speed.
  output logic      run_enable,
  output logic      full_speed,
  output logic      no_protective_stop,
  // Status outputs.
  output logic      seq_error,
  output logic      await_operator
);

  //////////////////////////////////////////////////////////////////////////////

  logic outer_s;
  logic inner_s;
  logic estop_s;
  logic reset_s;
  logic restart_s;
  logic reset_press;
  logic restart_press;

  pfsm_sync #(.INIT(`PFSM_FIELD_BLOCKED)) u_sync_outer (
    .clk   (clk),
    .reset (reset),
    .din   (outer_field),
    .dout  (outer_s)
  );

  pfsm_sync #(.INIT(`PFSM_FIELD_BLOCKED)) u_sync_inner (
    .clk   (clk),
    .reset (reset),
    .din   (inner_field),
    .dout  (inner_s)
  );

  pfsm_sync #(.INIT(`PFSM_BUTTON_ON)) u_sync_estop (
    .clk   (clk),
    .reset (reset),
    .din   (estop_btn),
    .dout  (estop_s)
  );

  pfsm_sync #(.INIT(`PFSM_BUTTON_ON)) u_sync_reset (
    .clk   (clk),
    .reset (reset),
    .din   (reset_btn),
    .dout  (reset_s)
  );

  pfsm_sync #(.INIT(`PFSM_BUTTON_ON)) u_sync_restart (
    .clk   (clk),
    .reset (reset),
    .din   (restart_btn),
    .dout  (restart_s)
  );

  pfsm_buttons u_buttons (
    .clk           (clk),
    .reset         (reset),
    .reset_btn     (reset_s),
    .restart_btn   (restart_s),
    .reset_press   (reset_press),
    .restart_press (restart_press)
  );

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    pfsm_state_t state;
    logic        outer_prev;
    logic        inner_prev;
    logic        run;
    logic        speed;
    logic        no_stop;
    logic        err;
    logic        wait_op;
  } pfsm_st_t;

  pfsm_st_t s_q;
  pfsm_st_t s_d;

  logic outer_free;
  logic inner_free;
  logic fault_any;
  logic estop_on;
  logic outer_freed;
  logic inner_freed;
  logic inner_hit;
  logic outer_hit;
  logic all_free;
  logic motion_ok;

  assign outer_free  = (outer_s == `PFSM_FIELD_FREE); // R13
  assign inner_free  = (inner_s == `PFSM_FIELD_FREE); // R13
  assign fault_any   = ctrl_fault | module_fault | scanner_fault | link_lost; // R5 R6
  assign estop_on    = (estop_s == `PFSM_BUTTON_ON);
  assign outer_freed = outer_free && (s_q.outer_prev != `PFSM_FIELD_FREE);
  assign inner_freed = inner_free && (s_q.inner_prev != `PFSM_FIELD_FREE);
  assign inner_hit   = !inner_free && (s_q.inner_prev == `PFSM_FIELD_FREE);
  assign outer_hit   = !outer_free && (s_q.outer_prev == `PFSM_FIELD_FREE);
  assign all_free    = outer_free && inner_free; // R9

  // Sequence monitor; faults and emergency stop drop to the operator path.
  always_comb begin
    s_d = s_q;
    s_d.outer_prev = outer_s;
    s_d.inner_prev = inner_s;
    case (s_q.state) // R10
      PFSM_INIT: begin
        s_d.state = PFSM_ERROR;
      end
      PFSM_NO_FIELD: begin
        if (!inner_free) begin
          s_d.state = PFSM_ERROR; // R15
        end else if (!outer_free) begin
          s_d.state = PFSM_OUTER_IN;
        end
      end
      PFSM_OUTER_IN: begin
        if (outer_free) begin
          s_d.state = inner_free ? PFSM_NO_FIELD : PFSM_ERROR; // R3
        end else if (!inner_free) begin
          s_d.state = PFSM_BOTH_IN;
        end
      end
      PFSM_BOTH_IN: begin
        if (outer_freed && inner_freed) begin
          s_d.state = PFSM_ERROR; // R14
        end else if (outer_free) begin
          s_d.state = PFSM_ERROR; // R3
        end else if (inner_free) begin
          s_d.state = PFSM_OUTER_OUT;
        end
      end
      PFSM_OUTER_OUT: begin
        if (!inner_free) begin
          s_d.state = PFSM_BOTH_IN;
        end else if (outer_free) begin
          s_d.state = PFSM_NO_FIELD; // R11
        end
      end
      PFSM_ERROR: begin
        if (reset_press && all_free && !estop_on && !fault_any) begin
          s_d.state = PFSM_WAIT_RESTART; // R16
        end
      end
      PFSM_WAIT_RESTART: begin
        if (!all_free) begin
          s_d.state = PFSM_ERROR;
        end else if (restart_press) begin
          s_d.state = PFSM_NO_FIELD; // R12 R16
        end
      end
      default: begin
        s_d.state = PFSM_ERROR;
      end
    endcase
    if (estop_on || fault_any) begin
      s_d.state = PFSM_ERROR; // R4 R17
    end
    s_d.err        = (s_d.state == PFSM_ERROR);
    s_d.wait_op    = (s_d.state == PFSM_ERROR) || (s_d.state == PFSM_WAIT_RESTART);
    // Motion is allowed only before the inner field is reached; the walk-out keeps the stop.
    motion_ok      = (s_d.state == PFSM_NO_FIELD) || (s_d.state == PFSM_OUTER_IN);
    // Safe state: outputs at the downtime level; run only in a permitted state.
    if (fault_any || estop_on || s_d.wait_op) begin
      s_d.run     = `PFSM_OUT_SAFE; // R1 R5 R6
      s_d.speed   = `PFSM_OUT_SAFE;
      s_d.no_stop = `PFSM_OUT_SAFE;
    end else begin
      s_d.run     = (inner_free && motion_ok) ? `PFSM_OUT_RUN : `PFSM_OUT_SAFE; // R2 R9
      s_d.no_stop = (inner_free && motion_ok) ? `PFSM_OUT_RUN : `PFSM_OUT_SAFE; // R8 R17
      s_d.speed   = outer_free ? `PFSM_OUT_RUN : `PFSM_OUT_SAFE; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{state:      PFSM_INIT,
               outer_prev: `PFSM_FIELD_BLOCKED,
               inner_prev: `PFSM_FIELD_BLOCKED,
               run:        `PFSM_OUT_SAFE,
               speed:      `PFSM_OUT_SAFE,
               no_stop:    `PFSM_OUT_SAFE,
               err:        `PFSM_FLAG_CLEAR,
               wait_op:    `PFSM_FLAG_SET};
    end else begin
      s_q <= s_d;
    end
  end

  assign run_enable         = s_q.run;
  assign full_speed         = s_q.speed;
  assign no_protective_stop = s_q.no_stop;
  assign seq_error          = s_q.err;
  assign await_operator     = s_q.wait_op;

  //////////////////////////////////////////////////////////////////////////////

  fault_safe_a: assert property (@(posedge clk) disable iff (reset)
    fault_any |=> (run_enable == `PFSM_OUT_SAFE && no_protective_stop == `PFSM_OUT_SAFE)) // R5
    else $error("Fault did not force outputs low.");

  link_safe_a: assert property (@(posedge clk) disable iff (reset)
    link_lost |=> !run_enable && !full_speed) // R6
    else $error("Lost link did not force outputs low.");

  inner_stop_a: assert property (@(posedge clk) disable iff (reset)
    !inner_free |=> !no_protective_stop && !run_enable) // R2
    else $error("Interrupted inner field did not stop the robot.");

  estop_safe_a: assert property (@(posedge clk) disable iff (reset)
    estop_on |=> !run_enable ##0 seq_error) // R4
    else $error("Emergency stop did not enter the safe state.");

  outer_slow_a: assert property (@(posedge clk) disable iff (reset)
    !outer_free |=> !full_speed) // R7
    else $error("Interrupted outer field did not request reduced speed.");

  run_free_a: assert property (@(posedge clk) disable iff (reset)
    $rose(run_enable) |-> $past(all_free)) // R9
    else $error("Restart while a field was interrupted.");

  early_inner_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.state == PFSM_NO_FIELD && !inner_free && !estop_on && !fault_any) |=> seq_error) // R15
    else $error("Inner field before outer field was not flagged.");

  both_freed_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.state == PFSM_BOTH_IN && outer_freed && inner_freed) |=> seq_error) // R14
    else $error("Simultaneous freeing was not flagged.");

  error_latch_a: assert property (@(posedge clk) disable iff (reset)
    (seq_error && !reset_press) |=> seq_error) // R17
    else $error("Error state left without a reset press.");

  operator_only_a: assert property (@(posedge clk) disable iff (reset)
    (await_operator && !restart_press) |=> !run_enable) // R12
    else $error("Restart after an error without operator action.");

  auto_restart_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.state == PFSM_OUTER_OUT && all_free && !estop_on && !fault_any) |=> run_enable) // R11
    else $error("Completed walk-out did not restart the robot.");

  inner_entry_a: assert property (@(posedge clk) disable iff (reset)
    inner_hit |=> !run_enable) // R8
    else $error("Inner field entry did not stop the robot.");

  restart_refused_a: assert property (@(posedge clk) disable iff (reset)
    (seq_error && restart_press) |=> !run_enable) // R12
    else $error("Restart press accepted before a reset press.");

  early_outer_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.state == PFSM_BOTH_IN && outer_free) |=> seq_error) // R3
    else $error("Outer field freed before inner field was not flagged.");

  cover_auto_restart: cover property (@(posedge clk) disable iff (reset)
    s_q.state == PFSM_OUTER_OUT ##1 s_q.state == PFSM_NO_FIELD);
  cover_manual_restart: cover property (@(posedge clk) disable iff (reset)
    s_q.state == PFSM_WAIT_RESTART ##1 s_q.state == PFSM_NO_FIELD);
  cover_seq_error: cover property (@(posedge clk) disable iff (reset)
    s_q.state == PFSM_BOTH_IN ##1 s_q.state == PFSM_ERROR);
  cover_estop: cover property (@(posedge clk) disable iff (reset)
    run_enable ##1 estop_on);
  cover_outer_entry: cover property (@(posedge clk) disable iff (reset)
    outer_hit && s_q.state == PFSM_NO_FIELD);

endmodule

// ### pfsm_robot_model.sv
`timescale 1ns/1ps

module pfsm_robot_model
  import pfsm_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Networked safety outputs from the monitor.
  input  wire logic run_enable,
  input  wire logic full_speed,
  input  wire logic no_protective_stop,
  // Robot motion as the controller applies it.
  output logic      moving,
  output logic      slow
);
  typedef struct packed {
    logic moving;
    logic slow;
  } pfsm_robot_t;

  pfsm_robot_t state_q;
  pfsm_robot_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // A low level on any output stops or slows the robot on the next edge.
  always_comb begin
    state_d        = state_q;
    state_d.moving = run_enable & no_protective_stop;
    state_d.slow   = ~full_speed;
    if (reset) begin
      state_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign moving = state_q.moving;
  assign slow   = state_q.slow;
endmodule

// ### pfsm_monitor_bench.sv
`timescale 1ns/1ps

module pfsm_monitor_bench
  import pfsm_pkg::*;
;
  logic        clk, reset, outer_field, inner_field, estop_btn, reset_btn, restart_btn;
  logic        ctrl_fault, module_fault, scanner_fault, link_lost;
  logic        run_enable, full_speed, no_protective_stop, seq_error, await_operator;
  logic        moving;
  int          n_mismatch, n_compared, k, f;
  integer      seed;
  logic [31:0] r;
  pfsm_state_t s;

  pfsm_monitor u_pfsm_monitor (.clk(clk), .reset(reset), .outer_field(outer_field),
    .inner_field(inner_field), .estop_btn(estop_btn), .reset_btn(reset_btn),
    .restart_btn(restart_btn), .ctrl_fault(ctrl_fault), .module_fault(module_fault),
    .scanner_fault(scanner_fault), .link_lost(link_lost), .run_enable(run_enable),
    .full_speed(full_speed), .no_protective_stop(no_protective_stop),
    .seq_error(seq_error), .await_operator(await_operator));

  pfsm_robot_model u_pfsm_robot_model (.clk(clk), .reset(reset), .run_enable(run_enable),
    .full_speed(full_speed), .no_protective_stop(no_protective_stop), .moving(moving),
    .slow());

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Output pattern {run, full, no_stop, error, await} for each monitor state.
  function automatic logic [4:0] exp_out(input pfsm_state_t st);
    case (st)
      PFSM_NO_FIELD:  exp_out = 5'h1C;
      PFSM_OUTER_IN:  exp_out = 5'h14;
      PFSM_OUTER_OUT,
      PFSM_BOTH_IN:   exp_out = 5'h00;
      PFSM_ERROR:     exp_out = 5'h03;
      default:        exp_out = 5'h01;
    endcase
  endfunction

  task automatic chk(input pfsm_state_t st, input int n, input logic [5:0] m = 6'h3F);
    logic [4:0] x;
    logic [5:0] e;
    logic [5:0] g;
    wait_n(n);
    x = exp_out(st);
    e = {x, x[4] & x[2]};
    g = {run_enable, full_speed, no_protective_stop, seq_error, await_operator, moving};
    n_compared++;
    if ((g & m) !== (e & m)) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask

  task automatic step(input logic o, input logic i, input pfsm_state_t st);
    outer_field = o;
    inner_field = i;
    chk(st, 8);
  endtask

  // A press of reset (sel 1) or restart (sel 0) is held past the input filter, then released.
  task automatic press(input logic sel);
    {reset_btn, restart_btn} = sel ? 2'h2 : 2'h1;
    wait_n(6);
    {reset_btn, restart_btn} = 2'h0;
    wait_n(6);
  endtask

  task automatic recover();
    press(1'h1);
    chk(PFSM_WAIT_RESTART, 1);
    press(1'h0);
    chk(PFSM_NO_FIELD, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    wait_n(20000);
    n_mismatch++;
    $display("BAD t=%0t exp=%h got=%h", $time, 1'h1, 1'h0);
    finish_test();
  end

  initial begin
    seed = 87;
    {reset, outer_field, inner_field} = 3'h7;
    {estop_btn, reset_btn, restart_btn, ctrl_fault, module_fault, scanner_fault, link_lost} = 7'h00;
    wait_n(2);
    reset = 1'h0;
    chk(PFSM_ERROR, 4);
    recover();
    s = PFSM_NO_FIELD;
    for (k = 0; k < 16; k++) begin
      r = $random(seed);
      case (s)
        PFSM_NO_FIELD: s = PFSM_OUTER_IN;
        PFSM_BOTH_IN:  s = PFSM_OUTER_OUT;
        default:       s = r[0] ? PFSM_BOTH_IN : PFSM_NO_FIELD;
      endcase
      step(s == PFSM_NO_FIELD, s != PFSM_BOTH_IN, s);
    end
    step(1'h0, 1'h1, (s == PFSM_NO_FIELD || s == PFSM_OUTER_IN) ? PFSM_OUTER_IN : PFSM_OUTER_OUT);
    step(1'h1, 1'h1, PFSM_NO_FIELD);
    step(1'h1, 1'h0, PFSM_ERROR);
    press(1'h1);
    chk(PFSM_ERROR, 1);
    step(1'h1, 1'h1, PFSM_ERROR);
    press(1'h0);
    chk(PFSM_ERROR, 1);
    recover();
    step(1'h0, 1'h1, PFSM_OUTER_IN);
    step(1'h0, 1'h0, PFSM_BOTH_IN);
    step(1'h1, 1'h1, PFSM_ERROR);
    recover();
    for (k = 0; k < 10; k++) begin
      f = $unsigned($random(seed)) % 5;
      {estop_btn, ctrl_fault, module_fault, scanner_fault, link_lost} = 5'h10 >> f;
      chk(PFSM_ERROR, (f == 0) ? 8 : 1, 6'h38);
      {estop_btn, ctrl_fault, module_fault, scanner_fault, link_lost} = 5'h00;
      chk(PFSM_ERROR, 8);
      recover();
    end
    finish_test();
  end
endmodule
